/* File: hw/sih_map.svh */
// Register map, field positions and reset values of the status and interrupt block
// Function
// - Top summary bit reads 1 while any per-output pending bit is 1.
// - Global gate at 0 keeps the global flag at 0.
// - Global flag equals gate and any of top bits 7 to 2.
// - A general-purpose pin can be set to follow the global flag.
// - Boot-done flag clears on reset and sets when auto-configuration finishes.
// - Per-output pending is any latched bit together with its enable.
// - Phase-adjust busy shows live from trigger until adjustment completes.
// - Phase-adjust armed shows live while armed, clears on trigger.
// - Slow-divider edge latch sets on rising edge while its status enable is on; write 1 clears.
// - Slow-divider level bit tracks divider live, 0 means high, 1 low.
// - Restart latch sets when the output clock resumes; write 1 clears.
// - Halt latch sets when the output clock stops; write 1 clears.
// - Halt live bit reads 1 while stopped, 0 while running.
// - Three enables per output gate latched bits into the pending bit.
// - Halt bits may start undefined and settle to 0 once clocked.
// - Slow-divider status enable off forces the level bit low.
`ifndef SIH_MAP_SVH
`define SIH_MAP_SVH

`define SIH_ADDR_W 10
`define SIH_TOP_ADDR 10'h042
`define SIH_GLOB_ADDR 10'h043
`define SIH_SUM_ADDR 10'h045
`define SIH_PA_ADDR 10'h04d
`define SIH_OUT1_ADDR 10'h053
`define SIH_OUT2_ADDR 10'h054
`define SIH_OUT3_ADDR 10'h055

`define SIH_TOP_SUM_BIT 5
`define SIH_TOP_GATE_BIT 1
`define SIH_TOP_FLAG_BIT 0
`define SIH_TOP_SRC_HI 7
`define SIH_TOP_SRC_LO 2
`define SIH_GLOB_BOOT_BIT 7
`define SIH_PA_BUSY_BIT 1
`define SIH_PA_ARMED_BIT 0
`define SIH_PA_RSVD 8'h84

`define SIH_OS_SLOW_IE 7
`define SIH_OS_SLOW_LAT 6
`define SIH_OS_SLOW_LVL 5
`define SIH_OS_RESTART_IE 4
`define SIH_OS_RESTART_LAT 3
`define SIH_OS_HALT_IE 2
`define SIH_OS_HALT_LAT 1
`define SIH_OS_HALT_LIVE 0

`define SIH_BYTE_RST 8'h00
`define SIH_SYNC_RST 1'b0

`endif

/* File: hw/sih_pkg.sv */
// Types shared by the status and interrupt block
package sih_pkg;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [9:0] addr;
        logic [7:0] wdata;
    } sih_req_type;

    typedef struct packed {
        logic slow_ie;
        logic slow_lat;
        logic restart_ie;
        logic restart_lat;
        logic halt_ie;
        logic halt_lat;
    } sih_out_type;

endpackage

/* File: hw/sih_sync.sv */
// Two-stage level synchroniser
`timescale 1ns/1ps
`default_nettype none
`include "sih_map.svh"
module sih_sync #(
    parameter int WIDTH = 1
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            meta_q <= {WIDTH{`SIH_SYNC_RST}};
            o_sync <= {WIDTH{`SIH_SYNC_RST}};
        end else begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end
endmodule
`default_nettype wire

/* File: hw/sih_top.sv */
// Status and interrupt hierarchy for three output clocks
`timescale 1ns/1ps
`default_nettype none
`include "sih_map.svh"
module sih_top #(
    parameter int N_OUT = 3
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire sih_pkg::sih_req_type i_req,
    input wire logic [N_OUT-1:0] i_slow_div_clk,
    input wire logic [N_OUT-1:0] i_out_halted,
    input wire logic [N_OUT-1:0] i_slow_div_status_en,
    input wire logic i_boot_done,
    input wire logic i_pa_armed,
    input wire logic i_pa_busy,
    input wire logic i_gpio_follow_irq,
    output logic [7:0] o_reg_rdata,
    output logic o_irq_flag,
    output logic o_gpio_irq
);
    sih_pkg::sih_out_type [N_OUT-1:0] os_q;
    sih_pkg::sih_out_type [N_OUT-1:0] os_d;
    logic [N_OUT-1:0] slow_s;
    logic [N_OUT-1:0] halt_s;
    logic [N_OUT-1:0] slow_p_q;
    logic [N_OUT-1:0] halt_p_q;
    logic [N_OUT-1:0] slow_rise;
    logic [N_OUT-1:0] halt_rise;
    logic [N_OUT-1:0] halt_fall;
    logic [N_OUT-1:0] pend_q;
    logic [N_OUT-1:0] pend_d;
    logic gate_q;
    logic boot_done_q;
    logic pa_armed_q;
    logic pa_busy_q;
    logic [7:0] top_rd;
    logic [7:0] rdata;

    function automatic logic [7:0] out_byte(input sih_pkg::sih_out_type s, input logic lvl, input logic live);
        logic [7:0] b;
        b = `SIH_BYTE_RST;
        b[`SIH_OS_SLOW_IE] = s.slow_ie;
        b[`SIH_OS_SLOW_LAT] = s.slow_lat;
        b[`SIH_OS_SLOW_LVL] = lvl;
        b[`SIH_OS_RESTART_IE] = s.restart_ie;
        b[`SIH_OS_RESTART_LAT] = s.restart_lat;
        b[`SIH_OS_HALT_IE] = s.halt_ie;
        b[`SIH_OS_HALT_LAT] = s.halt_lat;
        b[`SIH_OS_HALT_LIVE] = live;
        return b;
    endfunction

    function automatic logic out_sel(input logic [9:0] addr, input int idx);
        return addr == `SIH_OUT1_ADDR + 10'(idx);
    endfunction

    // Output clock domain levels into the register clock
    sih_sync #(.WIDTH(2 * N_OUT)) u_sync (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_async({i_slow_div_clk, i_out_halted}),
        .o_sync({slow_s, halt_s})
    );

    // Previous synchronised levels for edge detection
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            slow_p_q <= '0;
            halt_p_q <= '0;
        end else begin
            slow_p_q <= slow_s;
            halt_p_q <= halt_s;
        end
    end

    assign slow_rise = slow_s & ~slow_p_q & i_slow_div_status_en;
    assign halt_rise = halt_s & ~halt_p_q;
    assign halt_fall = ~halt_s & halt_p_q;

    // Per-output enables and latched bits
    always_comb begin
        os_d = os_q;
        for (int i = 0; i < N_OUT; i++) begin
            if (i_req.wr && out_sel(i_req.addr, i)) begin
                os_d[i].slow_ie = i_req.wdata[`SIH_OS_SLOW_IE];
                os_d[i].restart_ie = i_req.wdata[`SIH_OS_RESTART_IE];
                os_d[i].halt_ie = i_req.wdata[`SIH_OS_HALT_IE];
                os_d[i].slow_lat = os_q[i].slow_lat & ~i_req.wdata[`SIH_OS_SLOW_LAT];
                os_d[i].restart_lat = os_q[i].restart_lat & ~i_req.wdata[`SIH_OS_RESTART_LAT];
                os_d[i].halt_lat = os_q[i].halt_lat & ~i_req.wdata[`SIH_OS_HALT_LAT];
            end
            os_d[i].slow_lat = os_d[i].slow_lat | slow_rise[i];
            os_d[i].restart_lat = os_d[i].restart_lat | halt_fall[i];
            os_d[i].halt_lat = os_d[i].halt_lat | halt_rise[i];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            os_q <= '0;
        end else begin
            os_q <= os_d;
        end
    end

    // Per-output pending summary
    always_comb begin
        for (int i = 0; i < N_OUT; i++) begin
            pend_d[i] = (os_q[i].slow_lat & os_q[i].slow_ie)
                | (os_q[i].restart_lat & os_q[i].restart_ie)
                | (os_q[i].halt_lat & os_q[i].halt_ie);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pend_q <= '0;
        end else begin
            pend_q <= pend_d;
        end
    end

    // Global gate
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            gate_q <= 1'b0;
        end else if (i_req.wr && i_req.addr == `SIH_TOP_ADDR) begin
            gate_q <= i_req.wdata[`SIH_TOP_GATE_BIT];
        end
    end

    // Top status view
    always_comb begin
        top_rd = `SIH_BYTE_RST;
        top_rd[`SIH_TOP_SUM_BIT] = |pend_q;
        top_rd[`SIH_TOP_GATE_BIT] = gate_q;
        top_rd[`SIH_TOP_FLAG_BIT] = o_irq_flag;
    end

    // Global flag and pin follower
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_irq_flag <= 1'b0;
        end else begin
            o_irq_flag <= gate_q & (|top_rd[`SIH_TOP_SRC_HI:`SIH_TOP_SRC_LO]);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_gpio_irq <= 1'b0;
        end else begin
            o_gpio_irq <= i_gpio_follow_irq & o_irq_flag;
        end
    end

    // Boot-done flag
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            boot_done_q <= 1'b0;
        end else if (i_boot_done) begin
            boot_done_q <= 1'b1;
        end
    end

    // Live phase-adjust flags
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pa_armed_q <= 1'b0;
            pa_busy_q <= 1'b0;
        end else begin
            pa_armed_q <= i_pa_armed;
            pa_busy_q <= i_pa_busy;
        end
    end

    // Read decode
    always_comb begin
        rdata = `SIH_BYTE_RST;
        case (i_req.addr)
            `SIH_TOP_ADDR: begin
                rdata = top_rd;
            end
            `SIH_GLOB_ADDR: begin
                rdata[`SIH_GLOB_BOOT_BIT] = boot_done_q;
            end
            `SIH_SUM_ADDR: begin
                rdata[N_OUT-1:0] = pend_q;
            end
            `SIH_PA_ADDR: begin
                rdata = `SIH_PA_RSVD;
                rdata[`SIH_PA_BUSY_BIT] = pa_busy_q;
                rdata[`SIH_PA_ARMED_BIT] = pa_armed_q;
            end
            default: begin
                for (int i = 0; i < N_OUT; i++) begin
                    if (out_sel(i_req.addr, i)) begin
                        rdata = out_byte(os_q[i], i_slow_div_status_en[i] & ~slow_s[i], halt_s[i]);
                    end
                end
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_reg_rdata <= `SIH_BYTE_RST;
        end else if (i_req.rd) begin
            o_reg_rdata <= rdata;
        end
    end

    // Checks
    property p_gate_blocks;
        @(posedge i_clk) disable iff (i_rst)
        !gate_q |=> !o_irq_flag;
    endproperty
    a_gate_blocks: assert property (p_gate_blocks) else $error("flag set while gate off");

    property p_flag_cause;
        @(posedge i_clk) disable iff (i_rst)
        ##1 o_irq_flag == ($past(gate_q) && ($past(pend_q) != '0));
    endproperty
    a_flag_cause: assert property (p_flag_cause) else $error("flag does not match gate and sources");

    property p_summary;
        @(posedge i_clk) disable iff (i_rst)
        ##1 top_rd[`SIH_TOP_SUM_BIT] == $past(
            (os_q[0].slow_lat && os_q[0].slow_ie) || (os_q[0].restart_lat && os_q[0].restart_ie)
            || (os_q[0].halt_lat && os_q[0].halt_ie) || (os_q[1].slow_lat && os_q[1].slow_ie)
            || (os_q[1].restart_lat && os_q[1].restart_ie) || (os_q[1].halt_lat && os_q[1].halt_ie)
            || (os_q[2].slow_lat && os_q[2].slow_ie) || (os_q[2].restart_lat && os_q[2].restart_ie)
            || (os_q[2].halt_lat && os_q[2].halt_ie));
    endproperty
    a_summary: assert property (p_summary) else $error("summary bit wrong");

    property p_pending;
        @(posedge i_clk) disable iff (i_rst)
        (os_q[0].halt_lat && os_q[0].halt_ie) |=> pend_q[0];
    endproperty
    a_pending: assert property (p_pending) else $error("pending missed enabled halt");

    property p_no_pending;
        @(posedge i_clk) disable iff (i_rst)
        (os_q[1].slow_ie == 1'b0 && os_q[1].restart_ie == 1'b0 && os_q[1].halt_ie == 1'b0) |=> !pend_q[1];
    endproperty
    a_no_pending: assert property (p_no_pending) else $error("pending without enable");

    property p_halt_set;
        @(posedge i_clk) disable iff (i_rst)
        $rose(halt_s[0]) |=> os_q[0].halt_lat;
    endproperty
    a_halt_set: assert property (p_halt_set) else $error("halt latch not set");

    property p_restart_set;
        @(posedge i_clk) disable iff (i_rst)
        $fell(halt_s[2]) |=> os_q[2].restart_lat;
    endproperty
    a_restart_set: assert property (p_restart_set) else $error("restart latch not set");

    property p_slow_set;
        @(posedge i_clk) disable iff (i_rst)
        (slow_s[1] && !slow_p_q[1] && i_slow_div_status_en[1]) |=> os_q[1].slow_lat;
    endproperty
    a_slow_set: assert property (p_slow_set) else $error("slow edge latch not set");

    property p_set_wins;
        @(posedge i_clk) disable iff (i_rst)
        (halt_fall[0] && i_req.wr && i_req.addr == `SIH_OUT1_ADDR && i_req.wdata[`SIH_OS_RESTART_LAT])
            |=> os_q[0].restart_lat;
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event lost under clear");

    property p_boot_sticky;
        @(posedge i_clk) disable iff (i_rst)
        boot_done_q |=> boot_done_q;
    endproperty
    a_boot_sticky: assert property (p_boot_sticky) else $error("boot done dropped");

    property p_gpio_follow;
        @(posedge i_clk) disable iff (i_rst)
        i_gpio_follow_irq |=> o_gpio_irq == $past(o_irq_flag);
    endproperty
    a_gpio_follow: assert property (p_gpio_follow) else $error("pin does not follow flag");

    property p_sync_delay;
        @(posedge i_clk) disable iff (i_rst)
        ##2 halt_s[1] == $past(i_out_halted[1], 2);
    endproperty
    a_sync_delay: assert property (p_sync_delay) else $error("halt sync latency wrong");

    property p_busy_live;
        @(posedge i_clk) disable iff (i_rst)
        ##1 pa_busy_q == $past(i_pa_busy) && pa_armed_q == $past(i_pa_armed);
    endproperty
    a_busy_live: assert property (p_busy_live) else $error("phase flags not live");

    property p_level_off;
        @(posedge i_clk) disable iff (i_rst)
        (i_req.rd && i_req.addr == `SIH_OUT2_ADDR && !i_slow_div_status_en[1])
            |=> !o_reg_rdata[`SIH_OS_SLOW_LVL];
    endproperty
    a_level_off: assert property (p_level_off) else $error("level bit set while disabled");

    property p_level_live;
        @(posedge i_clk) disable iff (i_rst)
        (i_req.rd && i_req.addr == `SIH_OUT2_ADDR && i_slow_div_status_en[1])
            |=> o_reg_rdata[`SIH_OS_SLOW_LVL] == !$past(slow_s[1]);
    endproperty
    a_level_live: assert property (p_level_live) else $error("level bit not inverse of divider");

    property p_live_bit;
        @(posedge i_clk) disable iff (i_rst)
        (i_req.rd && i_req.addr == `SIH_OUT1_ADDR)
            |=> o_reg_rdata[`SIH_OS_HALT_LIVE] == $past(halt_s[0]);
    endproperty
    a_live_bit: assert property (p_live_bit) else $error("halt live bit wrong");

    property p_halt_clear;
        @(posedge i_clk) disable iff (i_rst)
        (i_req.wr && i_req.addr == `SIH_OUT1_ADDR && i_req.wdata[`SIH_OS_HALT_LAT] && !halt_rise[0])
            |=> !os_q[0].halt_lat;
    endproperty
    a_halt_clear: assert property (p_halt_clear) else $error("halt latch not cleared");

    property p_zero_keeps;
        @(posedge i_clk) disable iff (i_rst)
        (i_req.wr && i_req.addr == `SIH_OUT1_ADDR && !i_req.wdata[`SIH_OS_RESTART_LAT] && os_q[0].restart_lat)
            |=> os_q[0].restart_lat;
    endproperty
    a_zero_keeps: assert property (p_zero_keeps) else $error("zero write cleared latch");

    property p_pa_read;
        @(posedge i_clk) disable iff (i_rst)
        (i_req.rd && i_req.addr == `SIH_PA_ADDR)
            |=> (o_reg_rdata[`SIH_PA_BUSY_BIT] == $past(i_pa_busy, 2))
            && (o_reg_rdata[`SIH_PA_ARMED_BIT] == $past(i_pa_armed, 2));
    endproperty
    a_pa_read: assert property (p_pa_read) else $error("phase flags read wrong");

    property p_boot_clear;
        @(posedge i_clk) disable iff (i_rst)
        $fell(i_rst) |-> !boot_done_q;
    endproperty
    a_boot_clear: assert property (p_boot_clear) else $error("boot done survived reset");

    property p_gpio_off;
        @(posedge i_clk) disable iff (i_rst)
        !i_gpio_follow_irq |=> !o_gpio_irq;
    endproperty
    a_gpio_off: assert property (p_gpio_off) else $error("pin set while not following");

endmodule
`default_nettype wire

/* File: bench/sih_tb_top.sv */
// Self-checking testbench of the status and interrupt block
`timescale 1ns/1ps
`default_nettype none
`include "sih_map.svh"
module sih_tb_top;
    logic i_clk;
    logic i_rst;
    sih_pkg::sih_req_type i_req;
    logic [2:0] i_slow_div_clk;
    logic [2:0] i_out_halted;
    logic [2:0] i_slow_div_status_en;
    logic i_boot_done;
    logic i_pa_armed;
    logic i_pa_busy;
    logic i_gpio_follow_irq;
    logic [7:0] o_reg_rdata;
    logic o_irq_flag;
    logic o_gpio_irq;
    int n_fail;
    int cmp_count;
    int cycles;

    sih_top #(.N_OUT(3)) u_sih_top (
        .i_clk(i_clk), .i_rst(i_rst), .i_req(i_req), .i_slow_div_clk(i_slow_div_clk),
        .i_out_halted(i_out_halted), .i_slow_div_status_en(i_slow_div_status_en),
        .i_boot_done(i_boot_done), .i_pa_armed(i_pa_armed), .i_pa_busy(i_pa_busy),
        .i_gpio_follow_irq(i_gpio_follow_irq), .o_reg_rdata(o_reg_rdata),
        .o_irq_flag(o_irq_flag), .o_gpio_irq(o_gpio_irq)
    );

    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end

    task automatic report_and_stop();
        $display("Comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge i_clk) begin
        cycles++;
        if (cycles >= 5000) begin
            n_fail++;
            report_and_stop();
        end
    end

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(posedge i_clk);
    endtask

    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_req <= {1'b1, 1'b0, a, d};
        @(posedge i_clk);
        i_req.wr <= 1'b0;
    endtask

    task automatic rchk(input string what, input logic [9:0] a, input logic [7:0] exp);
        @(posedge i_clk);
        i_req <= {1'b0, 1'b1, a, 8'h00};
        @(posedge i_clk);
        i_req.rd <= 1'b0;
        @(posedge i_clk);
        #1;
        chk(what, exp, o_reg_rdata);
    endtask

    task automatic do_reset();
        @(posedge i_clk);
        i_rst <= 1'b1;
        wait_n(20);
        i_rst <= 1'b0;
        wait_n(1);
    endtask

    task automatic t_reset_vals();
        rchk("top", `SIH_TOP_ADDR, 8'h00);
        rchk("boot", `SIH_GLOB_ADDR, 8'h00);
        rchk("summary", `SIH_SUM_ADDR, 8'h00);
        rchk("phase", `SIH_PA_ADDR, 8'h84);
        for (int k = 0; k < 3; k++) rchk("out status", `SIH_OUT1_ADDR + 10'(k), 8'h00);
        rchk("unmapped", 10'h044, 8'h00);
        chk("flag", 8'h00, {7'h00, o_irq_flag});
        $display("Test reset values done");
    endtask

    task automatic t_globals();
        @(posedge i_clk);
        i_boot_done <= 1'b1;
        i_pa_armed <= 1'b1;
        wait_n(3);
        rchk("boot", `SIH_GLOB_ADDR, 8'h80);
        rchk("armed", `SIH_PA_ADDR, 8'h85);
        @(posedge i_clk);
        i_pa_armed <= 1'b0;
        i_pa_busy <= 1'b1;
        wait_n(3);
        rchk("busy", `SIH_PA_ADDR, 8'h86);
        @(posedge i_clk);
        i_pa_busy <= 1'b0;
        wait_n(3);
        rchk("idle", `SIH_PA_ADDR, 8'h84);
        wr(`SIH_GLOB_ADDR, 8'h00);
        rchk("boot ro", `SIH_GLOB_ADDR, 8'h80);
        $display("Test global flags done");
    endtask

    task automatic t_halt(input int k);
        logic [9:0] a;
        logic [7:0] bit_k;
        a = `SIH_OUT1_ADDR + 10'(k);
        bit_k = 8'h01 << k;
        wr(`SIH_TOP_ADDR, 8'h00);
        @(posedge i_clk);
        i_out_halted[k] <= 1'b1;
        wait_n(8);
        rchk("halt no ie", a, 8'h03);
        rchk("summary gated", `SIH_SUM_ADDR, 8'h00);
        wr(a, 8'h04);
        wait_n(4);
        rchk("halt ie", a, 8'h07);
        rchk("summary", `SIH_SUM_ADDR, bit_k);
        rchk("top gate off", `SIH_TOP_ADDR, 8'h20);
        chk("flag gate off", 8'h00, {7'h00, o_irq_flag});
        wr(`SIH_TOP_ADDR, 8'h02);
        wait_n(4);
        rchk("top gate on", `SIH_TOP_ADDR, 8'h23);
        @(posedge i_clk);
        i_gpio_follow_irq <= 1'b1;
        wait_n(3);
        #1;
        chk("pin", 8'h01, {7'h00, o_gpio_irq});
        @(posedge i_clk);
        i_gpio_follow_irq <= 1'b0;
        wait_n(3);
        #1;
        chk("pin off", 8'h00, {7'h00, o_gpio_irq});
        @(posedge i_clk);
        i_out_halted[k] <= 1'b0;
        wait_n(1);
        wr(a, 8'h0c);
        wait_n(4);
        rchk("restart kept", a, 8'h0e);
        wr(a, 8'h04);
        rchk("zero write", a, 8'h0e);
        wr(a, 8'h0e);
        wait_n(3);
        rchk("cleared", a, 8'h04);
        rchk("summary clear", `SIH_SUM_ADDR, 8'h00);
        chk("flag clear", 8'h00, {7'h00, o_irq_flag});
        wr(a, 8'h00);
        $display("Test halt and restart done");
    endtask

    task automatic t_slow();
        @(posedge i_clk);
        i_slow_div_status_en[1] <= 1'b1;
        wait_n(4);
        rchk("level low", `SIH_OUT1_ADDR + 10'h001, 8'h20);
        @(posedge i_clk);
        i_slow_div_clk[1] <= 1'b1;
        wait_n(6);
        rchk("edge", `SIH_OUT1_ADDR + 10'h001, 8'h40);
        wr(`SIH_OUT1_ADDR + 10'h001, 8'h80);
        wait_n(3);
        rchk("edge ie", `SIH_OUT1_ADDR + 10'h001, 8'hc0);
        rchk("summary", `SIH_SUM_ADDR, 8'h02);
        @(posedge i_clk);
        i_slow_div_clk[1] <= 1'b0;
        i_slow_div_status_en[1] <= 1'b0;
        wait_n(4);
        rchk("disabled", `SIH_OUT1_ADDR + 10'h001, 8'hc0);
        wr(`SIH_OUT1_ADDR + 10'h001, 8'hc0);
        wait_n(3);
        rchk("edge clear", `SIH_OUT1_ADDR + 10'h001, 8'h80);
        @(posedge i_clk);
        i_slow_div_clk[1] <= 1'b1;
        wait_n(6);
        rchk("no edge off", `SIH_OUT1_ADDR + 10'h001, 8'h80);
        @(posedge i_clk);
        i_slow_div_clk[1] <= 1'b0;
        wait_n(3);
        $display("Test slow divider done");
    endtask

    initial begin
        i_rst = 1'b1;
        i_req = '0;
        i_slow_div_clk = 3'h0;
        i_out_halted = 3'h0;
        i_slow_div_status_en = 3'h0;
        i_boot_done = 1'b0;
        i_pa_armed = 1'b0;
        i_pa_busy = 1'b0;
        i_gpio_follow_irq = 1'b0;
        n_fail = 0;
        cmp_count = 0;
        do_reset();
        t_reset_vals();
        t_globals();
        for (int k = 0; k < 3; k++) t_halt(k);
        t_slow();
        @(posedge i_clk);
        i_boot_done <= 1'b0;
        do_reset();
        t_reset_vals();
        report_and_stop();
    end
endmodule
`default_nettype wire
